// ===== design/control_front_params.svh
// Constants for the control front end: offsets, fields, resets, timing
`ifndef CONTROL_FRONT_PARAMS_SVH
`define CONTROL_FRONT_PARAMS_SVH
// ==========================================================
// Register addresses on the plain port and the serial port
`define ADDR_TARGET       4'h1
`define ADDR_STATUS       4'h2
`define ADDR_CTRL_B       4'h4
// ==========================================================
// Control register B fields
`define CTRL_SLEEP_BIT    0
`define CTRL_EXT_FLL_BIT  1
`define CTRL_PROBE_LSB    2
`define CTRL_PROBE_MSB    3
`define CTRL_DIVIDE_BIT   4
// ==========================================================
// Reset values
`define TARGET_RESET      16'h0100
`define CTRL_B_RESET      16'h0000
// ==========================================================
// Serial frame: address bits first, then data bits, MSB first
`define SER_ADDR_BITS     5'h4
`define SER_FRAME_BITS    5'h14
// ==========================================================
// Timing: retract time in microseconds, clock rate in MHz
`define RETRACT_TIME_US   10000
`define CLK_RATE_MHZ      10
`define RETRACT_CYCLES    (`RETRACT_TIME_US * `CLK_RATE_MHZ)
`endif

// ===== design/control_front_pkg.sv
// Types shared by the control front end
package control_front_pkg;
	// ==========================================================
	// Test mode decoded from the two mode pins
	typedef enum logic [1:0] {
		MODE_NORMAL  = 2'b00,
		MODE_PIN_MAP = 2'b01,
		MODE_HIZ     = 2'b10,
		MODE_PROBE   = 2'b11
	} test_mode_t;
	// ==========================================================
	// Low-voltage shutdown sequence
	typedef enum logic [1:0] {
		SEQ_RUN     = 2'b00,
		SEQ_CLEAR   = 2'b01,
		SEQ_RETRACT = 2'b10,
		SEQ_BRAKE   = 2'b11
	} shut_state_t;
	// ==========================================================
	// Pins that cross into the clock domain
	typedef struct packed {
		logic sclk;
		logic sdio;
		logic rw;
		logic select;
		logic testPin;
		logic qualifier;
		logic lowVoltage;
		logic probeIn;
		logic speedPulse;
	} pin_in_t;
	// ==========================================================
	// Power stage controls
	typedef struct packed {
		logic spinHighZ;
		logic syncRectEnable;
		logic retractEnable;
		logic brakeEnable;
	} power_ctl_t;
endpackage

// ===== design/control_front.sv
// Control front end: serial port, prescale, test modes, shutdown sequence
`timescale 1ns/1ps
`include "control_front_params.svh"

module control_front #(
	parameter int RETRACT_CYCLES = `RETRACT_CYCLES
) (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       resetn,
	// Asynchronous pins
	input  wire control_front_pkg::pin_in_t pinsIn,
	// Serial data line drive
	output logic                            sdioOut,
	output logic                            sdioOe,
	// Digital probe pin drive
	output logic                            probeOut,
	output logic                            probeOe,
	// Analog probe control
	output logic                            analogProbeEnable,
	output logic [1:0]                      analogProbeSelect,
	// Test mode indications
	output logic                            pinMapCheck,
	output logic                            hizCheck,
	// Power stage controls
	output control_front_pkg::power_ctl_t   powerCtl,
	// Speed loop outputs
	output logic                            speedTooSlow,
	output logic                            speedTooFast,
	// Register port
	input  wire logic [3:0]                 regAddr,
	input  wire logic [15:0]                regWdata,
	input  wire logic                       regWrite,
	input  wire logic                       regRead,
	output logic [15:0]                     regRdata
);
	// ==========================================================
	// Functions
	function automatic control_front_pkg::test_mode_t modeDecode(
		input logic testPin, input logic qualifier);
		modeDecode = control_front_pkg::test_mode_t'({qualifier, testPin});
	endfunction

	function automatic logic [15:0] regView(input logic [3:0] addr,
		input logic [15:0] target, input logic [15:0] ctrlB,
		input logic [15:0] status);
		if (addr == `ADDR_TARGET) begin
			regView = target;
		end else if (addr == `ADDR_CTRL_B) begin
			regView = ctrlB;
		end else if (addr == `ADDR_STATUS) begin
			regView = status;
		end else begin
			regView = 16'h0000;
		end
	endfunction

	// ==========================================================
	// Declarations
	control_front_pkg::pin_in_t    syncA;
	control_front_pkg::pin_in_t    syncB;
	control_front_pkg::pin_in_t    syncC;
	control_front_pkg::pin_in_t    pins;
	control_front_pkg::pin_in_t    pinsLast;
	control_front_pkg::shut_state_t shutState;
	control_front_pkg::test_mode_t mode;
	logic [15:0]                   speedTarget;
	logic [15:0]                   ctrlB;
	logic [15:0]                   status;
	logic [31:0]                   retractCount;
	logic                          divideToggle;
	logic                          tick;
	logic [4:0]                    bitCount;
	logic                          frameRead;
	logic [3:0]                    serAddr;
	logic [15:0]                   serShift;
	logic                          serCommit;
	logic                          sclkRise;
	logic                          frameStart;
	logic                          dataPhase;
	logic                          released;
	logic                          fllRef;
	logic                          refRise;
	logic [15:0]                   periodCount;
	logic                          sleepMode;

	// ==========================================================
	// Pin synchronisers, change taken when stages two and three agree
	// Previous filtered pins kept alongside for edge detection
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			syncA    <= '0;
			syncB    <= '0;
			syncC    <= '0;
			pins     <= '0;
			pinsLast <= '0;
		end else begin
			syncA    <= pinsIn;
			syncB    <= syncA;
			syncC    <= syncB;
			pins     <= (syncB & ~(syncB ^ syncC)) | (pins & (syncB ^ syncC));
			pinsLast <= pins;
		end
	end

	assign sclkRise   = pins.sclk & ~pinsLast.sclk;
	assign frameStart = pins.select & ~pinsLast.select;
	assign sleepMode  = ctrlB[`CTRL_SLEEP_BIT];

	// ==========================================================
	// Shutdown sequencer after low voltage
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shutState <= control_front_pkg::SEQ_CLEAR;
		end else begin
			case (shutState)
				control_front_pkg::SEQ_RUN: begin
					if (pins.lowVoltage) begin
						shutState <= control_front_pkg::SEQ_CLEAR;
					end
				end
				control_front_pkg::SEQ_CLEAR: begin
					shutState <= control_front_pkg::SEQ_RETRACT;
				end
				control_front_pkg::SEQ_RETRACT: begin
					if (retractCount == 32'(RETRACT_CYCLES - 1)) begin
						shutState <= control_front_pkg::SEQ_BRAKE;
					end
				end
				control_front_pkg::SEQ_BRAKE: begin
					if (!pins.lowVoltage) begin
						shutState <= control_front_pkg::SEQ_RUN;
					end
				end
				default: begin
					shutState <= control_front_pkg::SEQ_CLEAR;
				end
			endcase
		end
	end

	// Retract timer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			retractCount <= 32'h0000_0000;
		end else if (shutState == control_front_pkg::SEQ_RETRACT) begin
			retractCount <= retractCount + 32'h0000_0001;
		end else begin
			retractCount <= 32'h0000_0000;
		end
	end

	// Power stage controls from the sequence; qualifier pin not used
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			powerCtl <= 4'b1100;
		end else begin
			powerCtl.spinHighZ      <= (shutState ==
				control_front_pkg::SEQ_CLEAR) ||
				(shutState == control_front_pkg::SEQ_RETRACT);
			powerCtl.syncRectEnable <= (shutState ==
				control_front_pkg::SEQ_CLEAR) ||
				(shutState == control_front_pkg::SEQ_RETRACT);
			powerCtl.retractEnable  <= shutState ==
				control_front_pkg::SEQ_RETRACT;
			powerCtl.brakeEnable    <= shutState ==
				control_front_pkg::SEQ_BRAKE;
		end
	end

	// ==========================================================
	// Registers, plain port wins over a serial commit in one cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			speedTarget <= `TARGET_RESET;
			ctrlB       <= `CTRL_B_RESET;
		end else if (shutState == control_front_pkg::SEQ_CLEAR) begin
			speedTarget <= `TARGET_RESET;
			ctrlB       <= `CTRL_B_RESET;
		end else if (regWrite) begin
			if (regAddr == `ADDR_TARGET) begin
				speedTarget <= regWdata;
			end else if (regAddr == `ADDR_CTRL_B) begin
				ctrlB <= regWdata;
			end
		end else if (serCommit) begin
			if (serAddr == `ADDR_TARGET) begin
				speedTarget <= {serShift[14:0], pins.sdio};
			end else if (serAddr == `ADDR_CTRL_B) begin
				ctrlB <= {serShift[14:0], pins.sdio};
			end
		end
	end

	assign status = {10'h000, speedTooFast, speedTooSlow,
		shutState, mode};

	// Read data one cycle after the strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			regRdata <= 16'h0000;
		end else if (regRead) begin
			regRdata <= regView(regAddr, speedTarget, ctrlB, status);
		end else begin
			regRdata <= 16'h0000;
		end
	end

	// ==========================================================
	// Serial port: address bits, then data bits, MSB first
	assign released  = sleepMode ||
		(shutState != control_front_pkg::SEQ_RUN) ||
		(mode == control_front_pkg::MODE_HIZ);
	assign dataPhase = bitCount >= `SER_ADDR_BITS;
	assign serCommit = pins.select && !frameRead && sclkRise &&
		(bitCount == `SER_FRAME_BITS - 5'h01);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bitCount  <= 5'h00;
			frameRead <= 1'b0;
			serAddr   <= 4'h0;
			serShift  <= 16'h0000;
		end else if (frameStart) begin
			bitCount  <= 5'h00;
			frameRead <= pins.rw;
		end else if (pins.select && sclkRise &&
			bitCount < `SER_FRAME_BITS) begin
			bitCount <= bitCount + 5'h01;
			if (!dataPhase) begin
				serAddr <= {serAddr[2:0], pins.sdio};
				if (bitCount == `SER_ADDR_BITS - 5'h01) begin
					serShift <= regView({serAddr[2:0], pins.sdio},
						speedTarget, ctrlB, status);
				end
			end else begin
				serShift <= {serShift[14:0], pins.sdio};
			end
		end
	end

	// Line driven only during read data phase of a live frame
	assign sdioOe  = pins.select && frameRead && dataPhase &&
		(bitCount < `SER_FRAME_BITS) && !released;
	assign sdioOut = sdioOe & serShift[15];

	// ==========================================================
	// Clock prescale tick
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			divideToggle <= 1'b0;
		end else begin
			divideToggle <= ~divideToggle;
		end
	end

	assign tick = !ctrlB[`CTRL_DIVIDE_BIT] || divideToggle;

	// ==========================================================
	// Test mode decode and probe pins
	assign mode        = modeDecode(pins.testPin, pins.qualifier);
	assign pinMapCheck = mode == control_front_pkg::MODE_PIN_MAP;
	assign hizCheck    = mode == control_front_pkg::MODE_HIZ;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			analogProbeEnable <= 1'b0;
			analogProbeSelect <= 2'b00;
		end else begin
			analogProbeEnable <= mode == control_front_pkg::MODE_PROBE;
			analogProbeSelect <= ctrlB[`CTRL_PROBE_MSB:`CTRL_PROBE_LSB];
		end
	end

	// Digital probe drives in probe mode, unless the loop takes it as clock input
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			probeOe  <= 1'b0;
			probeOut <= 1'b0;
		end else begin
			probeOe <= (mode == control_front_pkg::MODE_PROBE) &&
				!ctrlB[`CTRL_EXT_FLL_BIT];
			case (ctrlB[`CTRL_PROBE_MSB:`CTRL_PROBE_LSB])
				2'b00: probeOut <= tick;
				2'b01: probeOut <= pins.sclk;
				2'b10: probeOut <= powerCtl.retractEnable;
				default: probeOut <= speedTooSlow;
			endcase
		end
	end

	// ==========================================================
	// Speed loop: reference period in ticks against target
	assign fllRef  = ctrlB[`CTRL_EXT_FLL_BIT] ? pins.probeIn :
		pins.speedPulse;
	assign refRise = fllRef & ~(ctrlB[`CTRL_EXT_FLL_BIT] ?
		pinsLast.probeIn : pinsLast.speedPulse);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			periodCount  <= 16'h0000;
			speedTooSlow <= 1'b0;
			speedTooFast <= 1'b0;
		end else if (shutState != control_front_pkg::SEQ_RUN) begin
			periodCount  <= 16'h0000;
			speedTooSlow <= 1'b0;
			speedTooFast <= 1'b0;
		end else if (refRise) begin
			periodCount  <= 16'h0000;
			speedTooSlow <= periodCount > speedTarget;
			speedTooFast <= periodCount < speedTarget;
		end else if (tick && periodCount != 16'hFFFF) begin
			periodCount <= periodCount + 16'h0001;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_line_released: assert property (released |-> !sdioOe)
		else $error("data line driven while released");
	a_drive_read_only: assert property (sdioOe |-> frameRead &&
		dataPhase) else $error("line driven outside read data");
	a_low_volt_clear: assert property (shutState ==
		control_front_pkg::SEQ_CLEAR |=> speedTarget == `TARGET_RESET
		&& ctrlB == `CTRL_B_RESET) else $error("regs not cleared");
	a_clear_hiz_rect: assert property (shutState ==
		control_front_pkg::SEQ_CLEAR |=> powerCtl.spinHighZ &&
		powerCtl.syncRectEnable) else $error("stage not released");
	a_retract_first: assert property (powerCtl.brakeEnable &&
		!$past(powerCtl.brakeEnable) |-> $past(powerCtl.retractEnable))
		else $error("brake without prior retract");
	a_no_brake_retract: assert property (!(powerCtl.brakeEnable &&
		powerCtl.retractEnable)) else $error("brake with retract");
	a_mode_decode: assert property (pins.testPin &&
		pins.qualifier |=> analogProbeEnable)
		else $error("probe modes not started");
	a_pin_map: assert property (pinMapCheck == (pins.testPin &&
		!pins.qualifier)) else $error("pin map check decode wrong");
	a_ext_loop_in: assert property (ctrlB[`CTRL_EXT_FLL_BIT] |=>
		!probeOe) else $error("probe pin driven as loop input");
	a_prescale_tick: assert property (ctrlB[`CTRL_DIVIDE_BIT] && tick
		##1 ctrlB[`CTRL_DIVIDE_BIT] |-> !tick)
		else $error("divided tick not halved");
	a_speed_slow: assert property (refRise &&
		shutState == control_front_pkg::SEQ_RUN &&
		periodCount > speedTarget |=> speedTooSlow)
		else $error("slow speed not flagged");

	c_read_frame: cover property (sdioOe ##1 sdioOe);
	c_full_shutdown: cover property (powerCtl.retractEnable ##1
		powerCtl.brakeEnable);
	c_probe_mode: cover property (analogProbeEnable && probeOe);
endmodule // control_front

// ===== tb/serial_host.sv
// Host model that drives the serial control port of the front end
`timescale 1ns/1ps

module serial_host (
	// Clock
	input  wire logic clk,
	// Serial pins driven by the host
	output logic      sclk,
	output logic      hostData,
	output logic      hostOe,
	output logic      rw,
	output logic      select,
	// Data line level and device drive
	input  wire logic sdioLine,
	input  wire logic devOe
);
	int clash = 0;

	// Both ends driving the data line at once
	always @(posedge clk) begin
		if (hostOe && devOe)
			clash <= clash + 1;
	end

	initial begin
		sclk = 1'b0;
		hostData = 1'b0;
		hostOe = 1'b0;
		rw = 1'b0;
		select = 1'b0;
	end

	// ==========================================================
	// One frame: 4 address bits, 16 data bits, MSB first
	task automatic frame(input logic read, input logic [3:0] addr,
		input logic [15:0] wdata, input int half,
		output logic [15:0] rdata);
		logic [19:0] bits;
		bits = {addr, wdata};
		rdata = 16'h0000;
		@(posedge clk);
		rw <= read;
		repeat (half) @(posedge clk);
		select <= 1'b1;
		hostOe <= 1'b1;
		repeat (half) @(posedge clk);
		for (int i = 19; i >= 0; i--) begin
			hostData <= bits[i];
			repeat (half - 1) @(posedge clk);
			@(negedge clk);
			if (read && i <= 15)
				rdata[i] = sdioLine;
			@(posedge clk);
			sclk <= 1'b1;
			repeat (2) @(posedge clk);
			if (read && i == 16)
				hostOe <= 1'b0;
			repeat (half - 2) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (half) @(posedge clk);
		hostOe <= 1'b0;
		select <= 1'b0;
		repeat (half) @(posedge clk);
	endtask
endmodule // serial_host

// ===== tb/testbench.sv
// Testbench for the control front end: registers, serial, modes, shutdown
`timescale 1ns/1ps
`include "control_front_params.svh"

`define CHK(nm, e, g) begin \
	nTests++; \
	if ((g) !== (e)) begin \
		errTotal++; \
		$display("ERROR %s expected %h seen %h", nm, e, g); \
	end \
end

module testbench;
	localparam int RC = 8;
	logic                       clk = 1'b0;
	logic                       resetn = 1'b0;
	logic                       testPin = 1'b0;
	logic                       qualifier = 1'b0;
	logic                       lowVoltage = 1'b0;
	logic                       speedPulse = 1'b0;
	logic                       lastLevel = 1'b0;
	logic [3:0]                 regAddr = 4'h0;
	logic [15:0]                regWdata = 16'h0000;
	logic                       regWrite = 1'b0;
	logic                       regRead = 1'b0;
	logic                       sclk, hostData, hostOe, rw, select;
	logic                       sdioLine, sdioOut, sdioOe;
	logic                       probeLine;
	logic                       probeOut, probeOe, analogProbeEnable;
	logic [1:0]                 analogProbeSelect;
	logic                       pinMapCheck, hizCheck;
	logic                       speedTooSlow, speedTooFast;
	logic [15:0]                regRdata;
	logic [3:0]                 modeOut;
	control_front_pkg::pin_in_t pinsIn;
	control_front_pkg::power_ctl_t powerCtl;
	logic [31:0]                seed = 32'h0000_ebc9;
	int                         errTotal = 0;
	int                         nTests = 0;
	int                         cycles = 0;
	int                         driven = 0;
	int                         pCnt = 0;

	always #50 clk = ~clk;

	// Data line level from all drivers, inverse of last when released
	assign sdioLine = sdioOe ? sdioOut : (hostOe ? hostData : ~lastLevel);
	assign pinsIn = {sclk, sdioLine, rw, select, testPin, qualifier,
		lowVoltage, probeLine, speedPulse};
	// Probe pin: device drive, else an external loop clock of 20 cycles
	assign probeLine = probeOe ? probeOut : (pCnt < 10);
	assign modeOut = {pinMapCheck, hizCheck, analogProbeEnable, probeOe};

	// Line history, drive count, speed reference, timeout
	always @(posedge clk) begin
		lastLevel <= sdioLine;
		if (sdioOe === 1'b1)
			driven++;
		pCnt <= (pCnt == 19) ? 0 : pCnt + 1;
		if (pCnt == 19)
			speedPulse <= ~speedPulse;
		cycles++;
		if (cycles == 40000) begin
			errTotal++;
			finishTest();
		end
	end

	control_front #(.RETRACT_CYCLES(RC)) control_front_i (
		.clk(clk), .resetn(resetn), .pinsIn(pinsIn),
		.sdioOut(sdioOut), .sdioOe(sdioOe),
		.probeOut(probeOut), .probeOe(probeOe),
		.analogProbeEnable(analogProbeEnable),
		.analogProbeSelect(analogProbeSelect),
		.pinMapCheck(pinMapCheck), .hizCheck(hizCheck),
		.powerCtl(powerCtl), .speedTooSlow(speedTooSlow),
		.speedTooFast(speedTooFast), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata));

	serial_host serial_host_i (
		.clk(clk), .sclk(sclk), .hostData(hostData), .hostOe(hostOe),
		.rw(rw), .select(select), .sdioLine(sdioLine), .devOe(sdioOe));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Expected {pin map, high-Z, analog, probe drive} from {ext, test, qual}
	function automatic logic [3:0] expMode(input logic [2:0] v);
		return {v[1] & ~v[0], ~v[1] & v[0], v[1] & v[0],
			v[1] & v[0] & ~v[2]};
	endfunction

	// ==========================================================
	// Register port cycles
	task automatic regWr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask

	task automatic regRd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(negedge clk);
		d = regRdata;
	endtask

	// Retract for its full time, then brake
	task automatic shutdown();
		int n;
		n = 0;
		while (powerCtl.retractEnable !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		`CHK("brake early", 1'b0, powerCtl.brakeEnable)
		`CHK("highz rectify", 2'b11, powerCtl[3:2])
		n = 0;
		while (powerCtl.retractEnable === 1'b1 && n < 999) begin
			n++;
			@(negedge clk);
		end
		`CHK("retract time", RC, n)
		`CHK("brake after", 1'b1, powerCtl.brakeEnable)
	endtask

	task automatic waitRun();
		int n;
		n = 0;
		while (powerCtl !== 4'b0000 && n < 50) begin
			@(negedge clk);
			n++;
		end
		`CHK("power run", 4'b0000, powerCtl)
	endtask

	task automatic finishTest();
		if (errTotal == 0 && nTests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		logic [31:0] w;
		logic [15:0] rd;
		int h;
		int d0;
		repeat (10) @(negedge clk);
		`CHK("power reset", 4'b1100, powerCtl)
		`CHK("oe reset", 1'b0, sdioOe)
		resetn <= 1'b1;
		shutdown();
		waitRun();
		regRd(`ADDR_TARGET, rd);
		`CHK("target reset", `TARGET_RESET, rd)
		regRd(`ADDR_CTRL_B, rd);
		`CHK("ctrl reset", `CTRL_B_RESET, rd)
		regRd(4'h3, rd);
		`CHK("unmapped", 16'h0000, rd)
		for (int k = 0; k < 8; k++) begin
			w = rnd();
			regWr(`ADDR_TARGET, w[15:0]);
			regWr(`ADDR_STATUS, ~w[15:0]);
			regWr(`ADDR_CTRL_B, {11'h000, w[20:16]});
			regRd(`ADDR_TARGET, rd);
			`CHK("target", w[15:0], rd)
			regRd(`ADDR_CTRL_B, rd);
			`CHK("ctrl", {11'h000, w[20:16]}, rd)
			`CHK("probe select", w[19:18], analogProbeSelect)
		end
		regWr(`ADDR_CTRL_B, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			h = (k % 2) ? 10 : 6;
			w = rnd();
			serial_host_i.frame(1'b0, `ADDR_TARGET, w[15:0], h, rd);
			regRd(`ADDR_TARGET, rd);
			`CHK("serial write", w[15:0], rd)
			serial_host_i.frame(1'b1, `ADDR_TARGET, 16'h0000, h, rd);
			`CHK("serial read", w[15:0], rd)
		end
		regWr(`ADDR_CTRL_B, 16'h0001);
		d0 = driven;
		serial_host_i.frame(1'b1, `ADDR_TARGET, 16'h0000, 6, rd);
		`CHK("sleep drive", d0, driven)
		for (int m = 0; m < 8; m++) begin
			regWr(`ADDR_CTRL_B, {14'h0000, m[2], 1'b0});
			testPin <= m[1];
			qualifier <= m[0];
			repeat (10) @(posedge clk);
			@(negedge clk);
			`CHK("mode", expMode(m[2:0]), modeOut)
			`CHK("power in mode", 4'b0000, powerCtl)
			`CHK("probe out", m[1] & m[0] & ~m[2], probeOe & probeOut)
			regRd(`ADDR_STATUS, rd);
			`CHK("mode status", {m[0], m[1]}, rd[1:0])
		end
		testPin <= 1'b0;
		qualifier <= 1'b0;
		regWr(`ADDR_CTRL_B, 16'h0000);
		regWr(`ADDR_TARGET, 16'h0004);
		repeat (300) @(posedge clk);
		@(negedge clk);
		`CHK("too slow", 2'b10, {speedTooSlow, speedTooFast})
		regWr(`ADDR_TARGET, 16'hffff);
		repeat (300) @(posedge clk);
		@(negedge clk);
		`CHK("too fast", 2'b01, {speedTooSlow, speedTooFast})
		regWr(`ADDR_CTRL_B, 16'h0012);
		regWr(`ADDR_TARGET, 16'h000f);
		repeat (300) @(posedge clk);
		@(negedge clk);
		`CHK("ext halved", 2'b01, {speedTooSlow, speedTooFast})
		lowVoltage <= 1'b1;
		shutdown();
		lowVoltage <= 1'b0;
		waitRun();
		regRd(`ADDR_TARGET, rd);
		`CHK("target cleared", `TARGET_RESET, rd)
		`CHK("line clash", 0, serial_host_i.clash)
		finishTest();
	end
endmodule // testbench
